// file: bkm_map.svh
`ifndef BKM_MAP_SVH
`define BKM_MAP_SVH

// Register window: top 4 kB of the address space
`define BKM_WIN_PAGE 20'hfffff
`define BKM_OFF_REMAP 12'h220
`define BKM_OFF_RESET_CAUSE_STATUS 12'h230
`define BKM_OFF_RESET_CAUSE_CLEAR 12'h234
`define BKM_OFF_SER_LO 12'h238
`define BKM_OFF_SER_HI 12'h23c
`define BKM_OFF_CHK 12'h240

// Access sizes on the load/store bus
`define BKM_SZ_BYTE 2'h0
`define BKM_SZ_HALF 2'h1
`define BKM_SZ_WORD 2'h2

// Reset values and fields
`define BKM_REMAP_RST 8'h00
`define BKM_CAUSE_POR 0
`define BKM_REV_LSB 0
`define BKM_REV_MSB 7

// Boot image check
`define BKM_SIG_WORD 7'h05
`define BKM_SIG_MAGIC 32'h27011970
`define BKM_PAGE_WORDS 8'h80
`define BKM_TRIM_LAST 4'h7

// Timing, times in ms and clock in kHz
`define BKM_CLK_KHZ 40000
`define BKM_WD_KERNEL_MS 30
`define BKM_PASS_MS 5
`define BKM_DL_REFRESH_MS 10

`endif

// file: bkm_pkg.sv
package bkm_pkg;

	typedef enum logic [2:0] {
		K_CAL,
		K_SUM,
		K_DECIDE,
		K_PAD,
		K_USER,
		K_DLOAD
	} bkm_kstate_t;

	typedef struct packed {
		bkm_kstate_t st;
		logic [3:0] trim_i;
		logic [7:0] fidx;
		logic [31:0] sum;
		logic [31:0] sig;
		logic [23:0] pass_cnt;
		logic [23:0] rfsh_cnt;
		logic por;
		logic go_user;
		logic armed;
		logic [7:0] remap;
		logic [7:0] rst_sta;
		logic [31:0] ser_lo;
		logic [31:0] ser_hi;
		logic [31:0] chk;
		logic [31:0] rdata;
		logic trim_we;
		logic [2:0] trim_sel;
		logic [31:0] trim_data;
		logic wd_refresh;
	} bkm_state_t;

	typedef struct packed {
		logic [23:0] cnt;
		logic expired;
	} bkm_wd_state_t;

endpackage

// file: bkm_wdog_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bkm_wdog_if;
	logic en;
	logic [23:0] load;
	logic refresh;
	logic expired;

	modport ctl (output en, output load, output refresh, input expired);
	modport tmr (input en, input load, input refresh, output expired);
endinterface

`default_nettype wire

// file: bkm_wdog.sv
`timescale 1ns/1ps
`default_nettype none

module bkm_wdog (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control from the boot supervisor
	bkm_wdog_if.tmr w
);
	bkm_pkg::bkm_wd_state_t q, d;

	// Disabled timer stays preloaded so enabling starts a full period
	always_comb begin
		d = q;
		d.expired = 1'b0;
		if (rst) begin
			d = '0;
		end else if (!w.en || w.refresh) begin
			d.cnt = w.load;
		end else if (q.cnt == '0) begin
			d.expired = 1'b1;
			d.cnt = w.load;
		end else begin
			d.cnt = q.cnt - 24'h000001;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	assign w.expired = q.expired;

endmodule

`default_nettype wire

// file: bkm_boot.sv
// Notes on behaviour
// - Kernel copies factory trims after every reset
// - Kernel may leave registers off defaults
// - After power-on, watchdog runs 30 ms during kernel
// - After power-on, watchdog off at exit to user
// - Other resets keep user watchdog, refresh at user start
// - Download mode refreshes watchdog periodically
// - Normal pass takes about 5 ms
// - Download mode entered, left only by reset
// - SRAM writable only in download mode
// - Signature, checksum or debug-reset pin high needed, else download
// - Debug-reset pin high always starts user
// - Debug port blocked while kernel runs
// - Kernel revision in serial number high
// - Kernel writes checksum to checksum register
// - Registers decoded in top 4 kB
// - Any register accepts 32-bit access
// - Narrow read data little-endian aligned
// - Halfword write zeroes upper sixteen bits
// - Halfword read returns only sixteen bits
// - Cause-clear write clears cause flags
`timescale 1ns/1ps
`default_nettype none
`include "bkm_map.svh"

module bkm_boot #(
	parameter int WD_KERNEL_CYC = `BKM_WD_KERNEL_MS * `BKM_CLK_KHZ,
	parameter int PASS_CYC = `BKM_PASS_MS * `BKM_CLK_KHZ,
	parameter int DL_REFRESH_CYC = `BKM_DL_REFRESH_MS * `BKM_CLK_KHZ,
	// Arbitrary value
	parameter logic [7:0] KERNEL_REV = 8'h01
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reset_cause_in,
	// Debug-reset pin
	input wire logic debug_reset_pin_n,
	// Factory trim space and peripheral trim writes
	output logic [2:0] trim_idx,
	input wire logic [31:0] trim_rdata,
	output logic trim_we,
	output logic [2:0] trim_sel,
	output logic [31:0] trim_data,
	// Code page 0 read port, data one cycle after address
	output logic [6:0] flash_word_addr,
	input wire logic [31:0] flash_rdata,
	// User watchdog configuration
	input wire logic wdog_user_en,
	input wire logic [23:0] wdog_user_load,
	// Load/store register bus
	input wire logic [31:0] bus_addr,
	input wire logic [1:0] bus_size,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata,
	// Boot status and control
	output logic core_hold,
	output logic debug_block,
	output logic download_mode,
	output logic sram_write_allow,
	output logic user_start,
	output logic wdog_reset_req
);
	localparam logic [23:0] WD_K = 24'(WD_KERNEL_CYC);
	localparam logic [23:0] PASS_LAST = 24'(PASS_CYC - 1);
	localparam logic [23:0] DL_LAST = 24'(DL_REFRESH_CYC - 1);

	bkm_pkg::bkm_state_t q, d;
	bkm_wdog_if wd ();
	logic kernel;
	logic hit;

	bkm_wdog u_wdog (
		.clk(clk),
		.rst(rst),
		.w(wd.tmr)
	);

	assign kernel = q.st != bkm_pkg::K_USER && q.st != bkm_pkg::K_DLOAD;
	assign hit = bus_addr[31:12] == `BKM_WIN_PAGE;

	always_comb begin
		logic [31:0] rv;
		logic [31:0] wv;
		logic [7:0] widx;
		rv = '0;
		wv = '0;
		widx = q.fidx - 8'h01;
		d = q;
		d.trim_we = 1'b0;
		d.wd_refresh = 1'b0;

		// Kernel sequence
		unique case (q.st)
		bkm_pkg::K_CAL: begin
			d.trim_we = 1'b1;
			d.trim_sel = q.trim_i[2:0];
			d.trim_data = trim_rdata;
			if (q.trim_i == `BKM_TRIM_LAST) begin
				d.st = bkm_pkg::K_SUM;
				d.fidx = '0;
				d.sum = '0;
				d.ser_hi[`BKM_REV_MSB:`BKM_REV_LSB] = KERNEL_REV;
			end else begin
				d.trim_i = q.trim_i + 4'h1;
			end
		end
		bkm_pkg::K_SUM: begin
			// Read data lags the address by one cycle
			if (q.fidx != '0) begin
				if (widx[6:0] == `BKM_SIG_WORD) begin
					d.sig = flash_rdata;
				end else begin
					d.sum = q.sum + flash_rdata;
				end
			end
			if (q.fidx == `BKM_PAGE_WORDS) begin
				d.st = bkm_pkg::K_DECIDE;
			end else begin
				d.fidx = q.fidx + 8'h01;
			end
		end
		bkm_pkg::K_DECIDE: begin
			d.chk = q.sum;
			d.go_user = debug_reset_pin_n
				|| q.sig == `BKM_SIG_MAGIC
				|| q.sig == q.sum;
			d.st = bkm_pkg::K_PAD;
		end
		bkm_pkg::K_PAD: begin
			// Pad so that a normal pass has a fixed length
			if (q.pass_cnt >= PASS_LAST) begin
				if (q.go_user) begin
					d.st = bkm_pkg::K_USER;
					d.wd_refresh = !q.por;
					d.armed = !q.por;
				end else begin
					d.st = bkm_pkg::K_DLOAD;
					d.rfsh_cnt = '0;
				end
			end
		end
		bkm_pkg::K_USER: begin
			// A stale enable left over from boot cannot rearm
			d.armed = q.armed || !wdog_user_en;
		end
		bkm_pkg::K_DLOAD: begin
			// No exit from here except reset
			if (q.rfsh_cnt >= DL_LAST) begin
				d.rfsh_cnt = '0;
				d.wd_refresh = 1'b1;
			end else begin
				d.rfsh_cnt = q.rfsh_cnt + 24'h000001;
			end
		end
		endcase

		if (kernel && q.pass_cnt < PASS_LAST) begin
			d.pass_cnt = q.pass_cnt + 24'h000001;
		end

		// Register reads, narrow registers in the low lanes
		unique case (bus_addr[11:0])
		`BKM_OFF_REMAP: rv = {24'h0, q.remap};
		`BKM_OFF_RESET_CAUSE_STATUS: rv = {24'h0, q.rst_sta};
		`BKM_OFF_SER_LO: rv = q.ser_lo;
		`BKM_OFF_SER_HI: rv = q.ser_hi;
		`BKM_OFF_CHK: rv = q.chk;
		default: rv = '0;
		endcase
		if (!hit) begin
			rv = '0;
		end
		if (bus_size == `BKM_SZ_BYTE) begin
			rv = {24'h0, rv[7:0]};
		end else if (bus_size == `BKM_SZ_HALF) begin
			rv = {16'h0, rv[15:0]};
		end
		if (bus_rd) begin
			d.rdata = rv;
		end

		// Register writes, narrow writes zero the upper bits
		if (bus_size == `BKM_SZ_BYTE) begin
			wv = {24'h0, bus_wdata[7:0]};
		end else if (bus_size == `BKM_SZ_HALF) begin
			wv = {16'h0, bus_wdata[15:0]};
		end else begin
			wv = bus_wdata;
		end
		if (bus_wr && hit) begin
			unique case (bus_addr[11:0])
			`BKM_OFF_REMAP: d.remap = wv[7:0];
			`BKM_OFF_RESET_CAUSE_CLEAR: d.rst_sta = q.rst_sta & ~wv[7:0];
			`BKM_OFF_SER_LO: d.ser_lo = wv;
			`BKM_OFF_SER_HI: d.ser_hi = wv;
			`BKM_OFF_CHK: begin
				// The kernel's own checksum write takes priority
				if (q.st != bkm_pkg::K_DECIDE) begin
					d.chk = wv;
				end
			end
			default: ;
			endcase
		end

		if (rst) begin
			d = '0;
			d.st = bkm_pkg::K_CAL;
			d.por = reset_cause_in[`BKM_CAUSE_POR];
			d.rst_sta = reset_cause_in;
			d.remap = `BKM_REMAP_RST;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	// Watchdog control
	always_comb begin
		// Reset empties the counter, so reload it as the kernel starts
		wd.refresh = q.wd_refresh
			|| (q.st == bkm_pkg::K_CAL && q.trim_i == 4'h0);
		if (q.por && q.st != bkm_pkg::K_USER) begin
			wd.en = 1'b1;
			wd.load = WD_K;
		end else if (q.st == bkm_pkg::K_USER) begin
			wd.en = wdog_user_en && q.armed;
			wd.load = wdog_user_load;
		end else begin
			// User timeout must cover a whole kernel pass
			wd.en = wdog_user_en;
			wd.load = wdog_user_load;
		end
	end

	assign wdog_reset_req = wd.expired;
	assign trim_idx = q.trim_i[2:0];
	assign trim_we = q.trim_we;
	assign trim_sel = q.trim_sel;
	assign trim_data = q.trim_data;
	assign flash_word_addr = q.fidx[6:0];
	assign bus_rdata = q.rdata;
	assign core_hold = q.st != bkm_pkg::K_USER;
	assign debug_block = kernel;
	assign download_mode = q.st == bkm_pkg::K_DLOAD;
	assign sram_write_allow = download_mode;
	assign user_start = q.st == bkm_pkg::K_USER;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_pad_exit;
		q.st == bkm_pkg::K_PAD && q.pass_cnt >= PASS_LAST;
	endsequence

	sequence s_to_user;
		s_pad_exit ##0 q.go_user;
	endsequence

	debug_block_a: assert property (
		kernel |-> debug_block && core_hold
	) else $error("debug port open during kernel");

	sram_gate_a: assert property (
		sram_write_allow |-> q.st == bkm_pkg::K_DLOAD
	) else $error("SRAM writable outside download");

	dl_sticky_a: assert property (
		download_mode |=> download_mode
	) else $error("download mode left without reset");

	pin_user_a: assert property (
		q.st == bkm_pkg::K_DECIDE && debug_reset_pin_n |=> q.go_user
	) else $error("debug pin high did not select user");

	chk_write_a: assert property (
		q.st == bkm_pkg::K_DECIDE |=> q.chk == $past(q.sum)
	) else $error("checksum register not written");

	unmapped_a: assert property (
		bus_rd && !hit |=> bus_rdata == '0
	) else $error("unmapped read not zero");

	half_write_a: assert property (
		bus_wr && hit && bus_size == `BKM_SZ_HALF
			&& bus_addr[11:0] == `BKM_OFF_CHK
			&& q.st != bkm_pkg::K_DECIDE
		|=> q.chk[31:16] == 16'h0000
	) else $error("halfword write left upper bits");

	por_exit_a: assert property (
		s_to_user ##0 q.por |=> !wd.en ##1 !wd.en
	) else $error("watchdog on after power-on exit");

	exit_refresh_a: assert property (
		s_to_user ##0 !q.por |=> q.wd_refresh && user_start
	) else $error("no watchdog refresh at exit");

	por_wd_a: assert property (
		q.por && kernel |-> wd.en && wd.load == WD_K
	) else $error("kernel watchdog not at kernel timeout");

	cal_len_a: assert property (
		$fell(rst) |=> trim_we [*8] ##1 q.st == bkm_pkg::K_SUM
	) else $error("trim copy not eight writes");

	clear_a: assert property (
		bus_wr && hit && bus_addr[11:0] == `BKM_OFF_RESET_CAUSE_CLEAR
		|=> (q.rst_sta & $past(bus_wdata[7:0])) == 8'h00
	) else $error("cause flags not cleared");

	wd_start_a: assert property (
		$fell(rst) |-> !wdog_reset_req ##1 !wdog_reset_req
	) else $error("watchdog fired as the kernel started");

	dl_enter_a: assert property (
		s_pad_exit ##0 !q.go_user |=> download_mode
	) else $error("bad image did not enter download");

	dl_gate_a: assert property (
		q.st == bkm_pkg::K_DECIDE && !debug_reset_pin_n
			&& q.sig != `BKM_SIG_MAGIC && q.sig != q.sum
		|=> !q.go_user
	) else $error("bad image selected user code");

	dl_refresh_a: assert property (
		download_mode && q.rfsh_cnt >= DL_LAST |=> q.wd_refresh
	) else $error("download mode missed a refresh");

	rd_zero_ext_a: assert property (
		bus_rd && bus_size == `BKM_SZ_BYTE |=> bus_rdata[31:8] == 24'h0
	) else $error("byte read not zero extended");

	user_hold_a: assert property (
		user_start |-> !core_hold && !debug_block && !sram_write_allow
	) else $error("core still held in user state");

endmodule

`default_nettype wire

// file: bkm_page_model.sv
`timescale 1ns/1ps
`default_nettype none

module bkm_page_model (
	// Clock
	input wire logic clk,
	// Image chosen by the bench
	input wire logic [31:0] base,
	input wire logic [31:0] sig_val,
	// Code page 0 and trim space
	input wire logic [6:0] flash_word_addr,
	output logic [31:0] flash_rdata,
	input wire logic [2:0] trim_idx,
	output logic [31:0] trim_rdata
);
	// Word 5 is byte address 0x14, the signature
	always_ff @(posedge clk) begin
		if (flash_word_addr == 7'h05)
			flash_rdata <= sig_val;
		else
			flash_rdata <= base + 32'h01000193 * {25'h0, flash_word_addr};
	end
	// Each index differs so a misrouted copy shows
	assign trim_rdata = {base[31:3], ~trim_idx};
endmodule

`default_nettype wire

// file: boot_kernel_mmr_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bkm_map.svh"

module boot_kernel_mmr_access_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] cause = 8'h00;
	logic pin = 1'b0;
	logic wen = 1'b0;
	logic [23:0] wload = 24'h0;
	logic [31:0] addr = 32'h0, wdata = 32'h0, base = 32'h0, sig = 32'h0;
	logic [1:0] size = 2'h0;
	logic wr = 1'b0, rd = 1'b0;
	logic [31:0] rdata, tdata, frd, trd, r, w;
	logic [6:0] fad;
	logic [2:0] tidx, tsel;
	logic twe, hold, dblk, dl, sram, ustart, wdr;
	int n_errors = 0, checks = 0, cyc, ntrim, nwd;

	bkm_boot #(.WD_KERNEL_CYC(300), .PASS_CYC(200), .DL_REFRESH_CYC(50),
		.KERNEL_REV(8'h5a)) uut (.clk(clk), .rst(rst), .reset_cause_in(cause),
		.debug_reset_pin_n(pin), .trim_idx(tidx), .trim_rdata(trd),
		.trim_we(twe), .trim_sel(tsel), .trim_data(tdata),
		.flash_word_addr(fad), .flash_rdata(frd), .wdog_user_en(wen),
		.wdog_user_load(wload), .bus_addr(addr), .bus_size(size),
		.bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata),
		.core_hold(hold), .debug_block(dblk), .download_mode(dl),
		.sram_write_allow(sram), .user_start(ustart), .wdog_reset_req(wdr));
	bkm_page_model pm (.clk(clk), .base(base), .sig_val(sig),
		.flash_word_addr(fad), .flash_rdata(frd), .trim_idx(tidx),
		.trim_rdata(trd));

	initial forever #12.5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [31:0] page_sum(input logic [31:0] b);
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 128; i++)
			if (i != 5)
				s += b + 32'h01000193 * i;
		return s;
	endfunction

	// One access: strobe one cycle, read data lands the edge after
	task automatic bus(input logic w_n, input logic [11:0] off,
		input logic [1:0] sz, input logic [31:0] d);
		@(negedge clk);
		addr = {`BKM_WIN_PAGE, off};
		size = sz;
		wdata = d;
		wr = w_n;
		rd = !w_n;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		r = rdata;
	endtask

	always @(negedge clk) begin
		if (wdr === 1'b1)
			nwd++;
		if (twe === 1'b1) begin
			check({29'h0, tsel}, ntrim);
			check(tdata, {base[31:3], ~ntrim[2:0]});
			ntrim++;
		end
	end

	// Image kind: 0 broken, 1 magic word, 2 page checksum
	task automatic boot(input logic [7:0] c, input logic p, input int k,
		input logic [23:0] wl);
		@(negedge clk);
		rst = 1'b1;
		cause = c;
		pin = p;
		base = $urandom;
		sig = k == 1 ? `BKM_SIG_MAGIC : page_sum(base) ^ {31'h0, k != 2};
		wen = wl != 24'h0;
		wload = wl;
		repeat (5) @(negedge clk);
		check({hold, dblk, dl, wdr}, 4'hc);
		check(rdata, 32'h0);
		rst = 1'b0;
		ntrim = 0;
		nwd = 0;
		cyc = 0;
		while (ustart !== 1'b1 && dl !== 1'b1) begin
			@(negedge clk);
			cyc++;
			if (cyc > 1000) begin
				n_errors++;
				complete_run();
			end
		end
		check(ntrim, 8);
		bus(1'b0, `BKM_OFF_CHK, `BKM_SZ_WORD, 32'h0);
		check(r, page_sum(base));
	endtask

	initial begin
		r = $urandom(75930);
		boot(8'h01, 1'b0, 0, 24'h0);
		check({dl, sram, ustart, hold}, 4'hd);
		repeat (400) @(negedge clk);
		check(nwd, 0);
		check(dl, 1'b1);
		$display("download test done");
		for (int k = 1; k < 4; k++) begin
			boot(8'h01, k == 3, k % 3, 24'd100);
			check({ustart, hold, dblk, sram, dl}, 5'h10);
			check(cyc >= 190 && cyc <= 210, 1'b1);
			repeat (400) @(negedge clk);
			check(nwd, 0);
			$display("user start test %0d done", k);
		end
		boot(8'h02, 1'b1, 0, 24'd320);
		repeat (250) @(negedge clk);
		check(nwd, 0);
		repeat (200) @(negedge clk);
		check(nwd, 1);
		bus(1'b0, `BKM_OFF_RESET_CAUSE_STATUS, `BKM_SZ_WORD, 32'h0);
		check(r, 32'h2);
		bus(1'b1, `BKM_OFF_RESET_CAUSE_CLEAR, `BKM_SZ_BYTE, 32'h2);
		bus(1'b0, `BKM_OFF_RESET_CAUSE_STATUS, `BKM_SZ_WORD, 32'h0);
		check(r, 32'h0);
		bus(1'b0, `BKM_OFF_REMAP, `BKM_SZ_WORD, 32'h0);
		check(r, 32'h0);
		bus(1'b0, `BKM_OFF_SER_HI, `BKM_SZ_BYTE, 32'h0);
		check(r, 32'h5a);
		for (int i = 0; i < 4; i++) begin
			w = $urandom;
			bus(1'b1, `BKM_OFF_SER_LO, `BKM_SZ_HALF, w);
			bus(1'b0, `BKM_OFF_SER_LO, `BKM_SZ_WORD, 32'h0);
			check(r, {16'h0, w[15:0]});
			bus(1'b1, `BKM_OFF_SER_LO, `BKM_SZ_WORD, w);
			bus(1'b0, `BKM_OFF_SER_LO, `BKM_SZ_WORD, 32'h0);
			check(r, w);
			bus(1'b0, `BKM_OFF_SER_LO, `BKM_SZ_HALF, 32'h0);
			check(r, {16'h0, w[15:0]});
			bus(1'b0, `BKM_OFF_SER_LO, `BKM_SZ_BYTE, 32'h0);
			check(r, {24'h0, w[7:0]});
			bus(1'b1, `BKM_OFF_CHK, `BKM_SZ_HALF, w);
			bus(1'b0, `BKM_OFF_CHK, `BKM_SZ_WORD, 32'h0);
			check(r, {16'h0, w[15:0]});
			bus(1'b1, `BKM_OFF_REMAP, `BKM_SZ_WORD, w);
			bus(1'b0, `BKM_OFF_REMAP, `BKM_SZ_WORD, 32'h0);
			check(r, {24'h0, w[7:0]});
			bus(1'b1, 12'h244, `BKM_SZ_WORD, ~w);
			bus(1'b0, 12'h244, `BKM_SZ_WORD, 32'h0);
			check(r, 32'h0);
			@(negedge clk);
			addr = 32'hfffe0238;
			wdata = ~w;
			wr = 1'b1;
			@(negedge clk);
			wr = 1'b0;
			bus(1'b0, `BKM_OFF_SER_LO, `BKM_SZ_WORD, 32'h0);
			check(r, w);
		end
		$display("register test done");
		complete_run();
	end
endmodule

`default_nettype wire
